/* inc/exec_map.svh */
// Opcode patterns, address constants and field positions for the exec unit
// Overview of operation
// - Add sums source and accumulator, sets both carries
// - Overflow is carry out of bit6 XOR bit7
// - Add forms: register, direct, indirect, immediate
// - Add-with-carry includes carry flag in sum
// - Page jump: PC+2 top five, opcode, byte
// - Page jump opcode low bits are 00001
// - Byte AND writes destination, flags unchanged
// - Port read-modify-write reads the output latch
// - Byte AND has six operand combinations
// - Carry AND clears carry on zero source
// - Carry AND source by direct bit address
// - Inverted carry AND 10110000 leaves bit intact
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

`define OPC_ADD_HI      4'h2
`define OPC_SUM_CIN_HI  4'h3
`define OPC_AND_HI      4'h5
`define OPC_LO_IMM      4'h4
`define OPC_LO_DIR      4'h5
`define OPC_LO_IND      3'h3
`define OPC_AND_DIR_A   8'h52
`define OPC_AND_DIR_IMM 8'h53
`define OPC_AND_C_BIT   8'h82
`define OPC_AND_C_NBIT  8'hB0
`define OPC_PJMP_LO     5'h01
`define PJMP_PC_STEP    16'h0002
`define BIT_AREA_BASE   8'h20
`define BANK_STRIDE_LSB 3

`endif

/* inc/exec_pkg.sv */
// Types shared by the decoder and the execution datapath
package exec_pkg;

  typedef enum logic [3:0] {
    OP_NONE, OP_ADD, OP_SUM_CIN, OP_PJMP, OP_AND_A, OP_AND_DIR_A,
    OP_AND_DIR_IMM, OP_AND_C, OP_AND_CN
  } op_kind_t;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_REG, SRC_DIR, SRC_IND, SRC_IMM, SRC_BIT
  } src_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PTR, ST_PTR_DATA, ST_READ, ST_EXEC
  } state_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  opcode;
    logic [7:0]  byte2;
    logic [7:0]  byte3;
  } instr_t;

  typedef struct packed {
    op_kind_t  kind;
    src_mode_t mode;
  } dec_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       indirect;
    logic       from_latch;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

endpackage

/* src/add_and_jump_exec_unit.sv */
// Execution datapath for add, add with carry, page jump and AND
`timescale 1ns/1ps
`include "exec_map.svh"

module add_and_jump_exec_unit
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [1:0]        bank_register_sel,
  input  wire logic              instr_valid,
  input  wire exec_pkg::instr_t  instr,
  output logic                   instr_ready,
  output exec_pkg::mem_req_t     mem_req,
  input  wire logic [7:0]        mem_rdata,
  output logic [7:0]             acc,
  output logic                   carry_flag,
  output logic                   half_carry_flag,
  output logic                   sign_error_flag,
  output logic                   pc_load,
  output logic [15:0]            pc_target,
  output logic                   done,
  output logic                   unsupported
);

  // ****************************************************************
  // Decode and state
  // ****************************************************************
  exec_pkg::dec_t     dec;
  exec_pkg::state_t   state_q;
  exec_pkg::op_kind_t kind_q;
  exec_pkg::instr_t   ins_q;
  logic [7:0]         acc_q;
  logic               carry_q;
  logic               half_q;
  logic               sign_q;
  logic [2:0]         bit_sel_q;
  exec_pkg::mem_req_t req_q;
  logic               pc_load_q;
  logic [15:0]        pc_target_q;
  logic               done_q;
  logic               unsup_q;
  logic               accept;

  exec_decode u_decode
  (
    .opcode (instr.opcode),
    .dec    (dec)
  );

  assign instr_ready = (state_q == exec_pkg::ST_IDLE);
  assign accept      = instr_valid && instr_ready;

  // ****************************************************************
  // Operand addressing
  // ****************************************************************
  logic [7:0] reg_addr;
  logic [7:0] ptr_addr;
  logic [7:0] bit_byte;
  logic       src_bit;
  logic [7:0] operand;

  assign reg_addr = {3'h0, bank_register_sel, instr.opcode[2:0]};
  assign ptr_addr = {3'h0, bank_register_sel, 2'h0, instr.opcode[0]};
  // Bit address to byte address: low half in bit area, high half in SFRs
  assign bit_byte = instr.byte2[7] ? {instr.byte2[7:3], 3'h0}
                                   : `BIT_AREA_BASE + {4'h0, instr.byte2[6:3]};
  assign src_bit  = mem_rdata[bit_sel_q];
  // Immediate data follows the opcode; for direct-dest AND it is third
  assign operand  = (kind_q == exec_pkg::OP_AND_DIR_IMM) ? ins_q.byte3
                  : mem_rdata;

  // ****************************************************************
  // Adder with carries out of bits 3, 6 and 7
  // ****************************************************************
  logic [7:0] add_src;
  logic       add_cin;
  logic [4:0] sum_lo;
  logic [3:0] sum_mid;
  logic [1:0] sum_hi;
  logic [7:0] sum;
  logic       c3;
  logic       c6;
  logic       c7;

  always_comb
  begin
    add_src = (state_q == exec_pkg::ST_EXEC && ins_q.opcode[3:0] == `OPC_LO_IMM
               && !ins_q.opcode[3]) ? ins_q.byte2 : mem_rdata;
    add_cin = (kind_q == exec_pkg::OP_SUM_CIN) ? carry_q : 1'b0;
  end

  assign sum_lo  = {1'b0, acc_q[3:0]} + {1'b0, add_src[3:0]}
                 + {4'h0, add_cin};
  assign c3      = sum_lo[4];
  assign sum_mid = {1'b0, acc_q[6:4]} + {1'b0, add_src[6:4]} + {3'h0, c3};
  assign c6      = sum_mid[3];
  assign sum_hi  = {1'b0, acc_q[7]} + {1'b0, add_src[7]} + {1'b0, c6};
  assign c7      = sum_hi[1];
  assign sum     = {sum_hi[0], sum_mid[2:0], sum_lo[3:0]};

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (reset)
      state_q <= exec_pkg::ST_IDLE;
    else
    begin
      unique case (state_q)
        exec_pkg::ST_IDLE:
          if (accept && dec.kind != exec_pkg::OP_NONE)
          begin
            unique case (dec.mode)
              exec_pkg::SRC_IND: state_q <= exec_pkg::ST_PTR;
              exec_pkg::SRC_IMM: state_q <= exec_pkg::ST_EXEC;
              exec_pkg::SRC_NONE: state_q <= exec_pkg::ST_IDLE;
              default:           state_q <= exec_pkg::ST_READ;
            endcase
          end
        exec_pkg::ST_PTR:      state_q <= exec_pkg::ST_PTR_DATA;
        exec_pkg::ST_PTR_DATA: state_q <= exec_pkg::ST_READ;
        exec_pkg::ST_READ:     state_q <= exec_pkg::ST_EXEC;
        exec_pkg::ST_EXEC:     state_q <= exec_pkg::ST_IDLE;
      endcase
    end
  end

  // Latch the instruction on acceptance
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      kind_q    <= exec_pkg::OP_NONE;
      ins_q     <= '0;
      bit_sel_q <= 3'h0;
    end
    else if (accept)
    begin
      kind_q    <= dec.kind;
      ins_q     <= instr;
      bit_sel_q <= instr.byte2[2:0];
    end
  end

  // ****************************************************************
  // Memory requests, registered
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (reset)
      req_q <= '0;
    else
    begin
      req_q <= '0;
      if (accept)
      begin
        unique case (dec.mode)
          exec_pkg::SRC_REG:
          begin
            req_q.rd   <= 1'b1;
            req_q.addr <= reg_addr;
          end
          exec_pkg::SRC_IND:
          begin
            req_q.rd   <= 1'b1;
            req_q.addr <= ptr_addr;
          end
          exec_pkg::SRC_DIR:
          begin
            req_q.rd   <= 1'b1;
            req_q.addr <= instr.byte2;
            // Read-modify-write of a port takes the output latch
            req_q.from_latch <= (dec.kind == exec_pkg::OP_AND_DIR_A) ||
                                (dec.kind == exec_pkg::OP_AND_DIR_IMM);
          end
          exec_pkg::SRC_BIT:
          begin
            req_q.rd   <= 1'b1;
            req_q.addr <= bit_byte;
          end
          default: req_q <= '0;
        endcase
      end
      else if (state_q == exec_pkg::ST_PTR_DATA)
      begin
        req_q.rd       <= 1'b1;
        req_q.indirect <= 1'b1;
        req_q.addr     <= mem_rdata;
      end
      else if (state_q == exec_pkg::ST_EXEC &&
               (kind_q == exec_pkg::OP_AND_DIR_A ||
                kind_q == exec_pkg::OP_AND_DIR_IMM))
      begin
        req_q.wr    <= 1'b1;
        req_q.addr  <= ins_q.byte2;
        req_q.wdata <= mem_rdata &
                       ((kind_q == exec_pkg::OP_AND_DIR_A) ? acc_q
                                                           : operand);
      end
    end
  end

  // ****************************************************************
  // Accumulator and flags
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (reset)
      acc_q <= 8'h00;
    else if (state_q == exec_pkg::ST_EXEC)
    begin
      if (kind_q == exec_pkg::OP_ADD || kind_q == exec_pkg::OP_SUM_CIN)
        acc_q <= sum;
      else if (kind_q == exec_pkg::OP_AND_A)
        acc_q <= acc_q & ((ins_q.opcode[3:0] == `OPC_LO_IMM)
                          ? ins_q.byte2 : mem_rdata);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      carry_q <= 1'b0;
      half_q  <= 1'b0;
      sign_q  <= 1'b0;
    end
    else if (state_q == exec_pkg::ST_EXEC)
    begin
      unique case (kind_q)
        exec_pkg::OP_ADD, exec_pkg::OP_SUM_CIN:
        begin
          carry_q <= c7;
          half_q  <= c3;
          sign_q  <= c6 ^ c7;
        end
        exec_pkg::OP_AND_C:
          if (!src_bit)
            carry_q <= 1'b0;
        exec_pkg::OP_AND_CN:
          if (src_bit)
            carry_q <= 1'b0;
        default: carry_q <= carry_q;
      endcase
    end
  end

  // ****************************************************************
  // Page jump and completion
  // ****************************************************************
  logic [15:0] pc_next;
  assign pc_next = ins_q.pc + `PJMP_PC_STEP;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pc_load_q   <= 1'b0;
      pc_target_q <= 16'h0000;
      done_q      <= 1'b0;
      unsup_q     <= 1'b0;
    end
    else
    begin
      pc_load_q <= 1'b0;
      done_q    <= 1'b0;
      unsup_q   <= 1'b0;
      if (accept && dec.kind == exec_pkg::OP_NONE)
      begin
        done_q  <= 1'b1;
        unsup_q <= 1'b1;
      end
      else if (state_q == exec_pkg::ST_EXEC)
      begin
        done_q <= 1'b1;
        if (kind_q == exec_pkg::OP_PJMP)
        begin
          pc_load_q   <= 1'b1;
          pc_target_q <= {pc_next[15:11], ins_q.opcode[7:5],
                          ins_q.byte2};
        end
      end
    end
  end

  assign mem_req         = req_q;
  assign acc             = acc_q;
  assign carry_flag      = carry_q;
  assign half_carry_flag = half_q;
  assign sign_error_flag = sign_q;
  assign pc_load         = pc_load_q;
  assign pc_target       = pc_target_q;
  assign done            = done_q;
  assign unsupported     = unsup_q;

endmodule

/* src/exec_decode.sv */
// Opcode decoder for add, page jump and AND instructions
`timescale 1ns/1ps
`include "exec_map.svh"

module exec_decode
(
  input  wire logic [7:0]      opcode,
  output exec_pkg::dec_t       dec
);

  logic [3:0] hi;
  logic [3:0] lo;
  exec_pkg::src_mode_t mode_lo;

  assign hi = opcode[7:4];
  assign lo = opcode[3:0];

  // Low nibble selects the source operand
  always_comb
  begin
    if (lo[3])
      mode_lo = exec_pkg::SRC_REG;
    else if (lo[3:1] == `OPC_LO_IND)
      mode_lo = exec_pkg::SRC_IND;
    else if (lo == `OPC_LO_DIR)
      mode_lo = exec_pkg::SRC_DIR;
    else if (lo == `OPC_LO_IMM)
      mode_lo = exec_pkg::SRC_IMM;
    else
      mode_lo = exec_pkg::SRC_NONE;
  end

  always_comb
  begin
    dec.kind = exec_pkg::OP_NONE;
    dec.mode = exec_pkg::SRC_NONE;
    if (opcode[4:0] == `OPC_PJMP_LO)
    begin
      dec.kind = exec_pkg::OP_PJMP;
      dec.mode = exec_pkg::SRC_IMM;
    end
    else if (opcode == `OPC_AND_DIR_A)
    begin
      dec.kind = exec_pkg::OP_AND_DIR_A;
      dec.mode = exec_pkg::SRC_DIR;
    end
    else if (opcode == `OPC_AND_DIR_IMM)
    begin
      dec.kind = exec_pkg::OP_AND_DIR_IMM;
      dec.mode = exec_pkg::SRC_DIR;
    end
    else if (opcode == `OPC_AND_C_BIT)
    begin
      dec.kind = exec_pkg::OP_AND_C;
      dec.mode = exec_pkg::SRC_BIT;
    end
    else if (opcode == `OPC_AND_C_NBIT)
    begin
      dec.kind = exec_pkg::OP_AND_CN;
      dec.mode = exec_pkg::SRC_BIT;
    end
    else if (mode_lo != exec_pkg::SRC_NONE)
    begin
      dec.mode = mode_lo;
      if (hi == `OPC_ADD_HI)
        dec.kind = exec_pkg::OP_ADD;
      else if (hi == `OPC_SUM_CIN_HI)
        dec.kind = exec_pkg::OP_SUM_CIN;
      else if (hi == `OPC_AND_HI)
        dec.kind = exec_pkg::OP_AND_A;
      else
        dec.mode = exec_pkg::SRC_NONE;
    end
  end

endmodule

/* tb/add_and_jump_exec_checker.sv */
// Port-level assertions for the execution unit
`timescale 1ns/1ps
module add_and_jump_exec_checker
(
  input wire logic               clk,
  input wire logic               reset,
  input wire logic [1:0]         bank_register_sel,
  input wire logic               instr_valid,
  input wire exec_pkg::instr_t   instr,
  input wire logic               instr_ready,
  input wire exec_pkg::mem_req_t mem_req,
  input wire logic [7:0]         mem_rdata,
  input wire logic [7:0]         acc,
  input wire logic               carry_flag,
  input wire logic               half_carry_flag,
  input wire logic               sign_error_flag,
  input wire logic               pc_load,
  input wire logic [15:0]        pc_target,
  input wire logic               done,
  input wire logic               unsupported
);
  logic        take;
  logic        rd_l;
  logic [4:0]  reg_a;
  logic [7:0]  op;
  logic [7:0]  m_addr;
  logic [7:0]  b2;
  logic [7:0]  mask;
  logic [15:0] pc_n;
  logic [15:0] tgt;

  assign take = instr_valid && instr_ready;
  assign op = instr.opcode;
  assign b2 = instr.byte2;
  assign mask = instr.byte3;
  assign rd_l = mem_req.rd && mem_req.from_latch;
  assign m_addr = mem_req.addr;
  assign reg_a = {bank_register_sel, op[2:0]};
  assign pc_n = instr.pc + 16'h0002;
  assign tgt = {pc_n[15:11], op[7:5], b2};

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_add_imm;
    take && op == 8'h24 |-> ##2 done && acc == $past(acc, 2) + $past(b2, 2);
  endproperty
  a_add_imm: assert property (p_add_imm) else $error("add imm");

  property p_reg_rd;
    take && op[7:3] == 5'h05 |=> mem_req.rd && !mem_req.indirect &&
      m_addr == {3'h0, $past(reg_a)};
  endproperty
  a_reg_rd: assert property (p_reg_rd) else $error("reg read");

  property p_jump;
    take && op[4:0] == 5'h01 |-> ##2 pc_load && pc_target == $past(tgt, 2);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target");

  property p_unknown;
    take && op == 8'hA5 |=> done && unsupported;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown op");

  property p_and_flags;
    take && op[7:4] == 4'h5 |=> ($stable(carry_flag) &&
      $stable(half_carry_flag) && $stable(sign_error_flag)) [*3];
  endproperty
  a_and_flags: assert property (p_and_flags) else $error("and flags");

  property p_wr_latch;
    mem_req.wr |-> $past(rd_l, 2) && $past(m_addr, 2) == m_addr;
  endproperty
  a_wr_latch: assert property (p_wr_latch) else $error("latch");

  property p_wr_data;
    take && op == 8'h53 |-> ##3 mem_req.wr &&
      mem_req.wdata == ($past(mem_rdata) & $past(mask, 3));
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("mask");

  property p_bit_keep;
    take && (op == 8'h82 || op == 8'hB0) |=> !mem_req.wr [*3];
  endproperty
  a_bit_keep: assert property (p_bit_keep) else $error("bit");

  property p_bit_done;
    take && op == 8'h82 |=> !done ##1 !done ##1 done;
  endproperty
  a_bit_done: assert property (p_bit_done) else $error("bit op");

  c_jump: cover property (pc_load);
  c_wr: cover property (mem_req.wr);
  c_unsup: cover property (unsupported);
endmodule

bind add_and_jump_exec_unit add_and_jump_exec_checker u_add_and_jump_exec_checker
(
  .clk, .reset, .bank_register_sel, .instr_valid, .instr, .instr_ready,
  .mem_req, .mem_rdata, .acc, .carry_flag, .half_carry_flag,
  .sign_error_flag, .pc_load, .pc_target, .done, .unsupported
);

/* tb/tb.sv */
// Self-checking bench for the add, page jump and AND execution unit
`timescale 1ns/1ps
module tb;
  logic               clk = 1'b0;
  logic               reset = 1'b1;
  logic [1:0]         bank_register_sel = 2'h0;
  logic               instr_valid = 1'b0;
  exec_pkg::instr_t   instr = '0;
  logic [7:0]         mem_rdata = 8'h00;
  exec_pkg::mem_req_t mem_req;
  logic               instr_ready, carry_flag, half_carry_flag;
  logic               sign_error_flag, pc_load, done, unsupported;
  logic [7:0]         acc;
  logic [15:0]        pc_target;
  logic [7:0]         ram [256];
  logic [7:0]         ind [256];
  logic [3:0]         lo [4] = '{4'hB, 4'h5, 4'h7, 4'h4};
  logic [7:0]         b2v [4] = '{8'h00, 8'h40, 8'h00, 8'hC3};
  logic [7:0]         sv [4] = '{8'hAA, 8'h3C, 8'h77, 8'hC3};
  logic [7:0]         bop [4] = '{8'h82, 8'h82, 8'hB0, 8'hB0};
  logic [7:0]         bad [4] = '{8'h0B, 8'h83, 8'h83, 8'h0B};
  logic               bv [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic [7:0]         ea, wa, wd;
  logic               ec, eh, eo, got_load, got_unsup, got_wr, got_lat;
  logic               hold = 1'b0;
  int                 errors = 0;
  int                 check_count = 0;

  always #2 clk = ~clk;

  add_and_jump_exec_unit u_add_and_jump_exec_unit
  (
    .clk, .reset, .bank_register_sel, .instr_valid, .instr, .instr_ready,
    .mem_req, .mem_rdata, .acc, .carry_flag, .half_carry_flag,
    .sign_error_flag, .pc_load, .pc_target, .done, .unsupported
  );

  // Read data valid two cycles, scrambled afterwards
  always @(negedge clk)
  begin
    if (mem_req.rd)
      mem_rdata <= mem_req.indirect ? ind[mem_req.addr] : ram[mem_req.addr];
    else if (!hold)
      mem_rdata <= ~mem_rdata;
    hold <= mem_req.rd;
  end

  always @(posedge clk)
    if (mem_req.wr)
      ram[mem_req.addr] <= mem_req.wdata;

  task automatic conclude;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic run(input logic [7:0] op, b2, b3, input logic [15:0] pc);
    int n;
    n = 0;
    got_lat = 1'b0;
    while (instr_ready !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    if (instr_ready !== 1'b1)
    begin
      chk("instr_ready", 16'h0001, 16'h0000);
      conclude();
    end
    instr_valid = 1'b1;
    instr = {pc, op, b2, b3};
    @(negedge clk);
    instr_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20)
    begin
      got_lat |= mem_req.rd & mem_req.from_latch;
      @(negedge clk);
      n++;
    end
    if (done !== 1'b1)
    begin
      chk("done", 16'h0001, 16'h0000);
      conclude();
    end
    got_load = pc_load;
    got_unsup = unsupported;
    got_wr = mem_req.wr;
    wa = mem_req.addr;
    wd = mem_req.wdata;
  endtask

  task automatic add_model(input logic [7:0] s, input logic ci);
    logic [8:0] t;
    t = {1'b0, ea} + s + ci;
    eh = ({1'b0, ea[3:0]} + s[3:0] + ci) > 5'h0F;
    eo = (({1'b0, ea[6:0]} + s[6:0] + ci) > 8'h7F) ^ t[8];
    ec = t[8];
    ea = t[7:0];
  endtask

  task automatic chkst;
    chk("acc", {8'h00, ea}, {8'h00, acc});
    chk("flags", {13'h0, ec, eh, eo},
        {13'h0, carry_flag, half_carry_flag, sign_error_flag});
  endtask

  task automatic test_add;
    bank_register_sel = 2'h2;
    ram[8'h13] = 8'hAA;
    ram[8'h40] = 8'h3C;
    ram[8'h11] = 8'h90;
    ind[8'h90] = 8'h77;
    {ea, ec, eh, eo} = '0;
    for (int f = 0; f < 4; f++)
      for (int h = 0; h < 2; h++)
      begin
        run({h ? 4'h3 : 4'h2, lo[f]}, b2v[f], 8'h00, 16'h0000);
        add_model(sv[f], h ? ec : 1'b0);
        chkst();
      end
    $display("add forms done");
  endtask

  task automatic test_jump;
    for (int k = 0; k < 8; k++)
    begin
      run({k[2:0], 5'h01}, 8'h5A, 8'h00, 16'h07FE);
      chk("pc_load", 16'h0001, {15'h0, got_load});
      chk("unsupported", 16'h0000, {15'h0, got_unsup});
      chk("pc_target", {5'h01, k[2:0], 8'h5A}, pc_target);
    end
    $display("page jump done");
  endtask

  task automatic test_and;
    for (int f = 0; f < 4; f++)
    begin
      run({4'h5, lo[f]}, b2v[f], 8'h00, 16'h0000);
      ea = ea & sv[f];
      chkst();
    end
    ram[8'h90] = 8'hF5;
    run(8'h53, 8'h90, 8'h73, 16'h0000);
    chk("latch read", 16'h0001, {15'h0, got_lat});
    chk("write", 16'h9071, {wa, wd});
    run(8'h52, 8'h90, 8'h00, 16'h0000);
    chk("strobe", 16'h0001, {15'h0, got_wr});
    chk("write", {8'h90, 8'h71 & ea}, {wa, wd});
    chkst();
    $display("byte and done");
  endtask

  task automatic test_carry_and;
    ram[8'h21] = 8'h08;
    ram[8'h80] = 8'hF7;
    for (int k = 0; k < 4; k++)
    begin
      run(8'h54, 8'h00, 8'h00, 16'h0000);
      run(8'h24, 8'hFF, 8'h00, 16'h0000);
      run(8'h24, 8'h01, 8'h00, 16'h0000);
      ea = 8'h00;
      add_model(8'hFF, 1'b0);
      add_model(8'h01, 1'b0);
      run(bop[k], bad[k], 8'h00, 16'h0000);
      ec = ec & (bv[k] ^ bop[k][5]);
      chkst();
      chk("bit write", 16'h0000, {15'h0, got_wr});
    end
    run(8'hA5, 8'h00, 8'h00, 16'h0000);
    chk("unsupported", 16'h0001, {15'h0, got_unsup});
    chkst();
    $display("carry and done");
  endtask

  initial
  begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    test_add();
    test_jump();
    test_and();
    test_carry_and();
    conclude();
  end
endmodule
